// File: rtl/irq_msg_pkg.sv
// Shared constants and types for the short interrupt message sender
package irq_msg_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_ENTRY_LO = 8'h00;
  localparam logic [7:0] OFF_ENTRY_HI = 8'h04;
  localparam logic [7:0] OFF_ARB_ID = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // Field positions
  localparam int VEC_LSB = 0;
  localparam int DMODE_LSB = 8;
  localparam int DESTMODE_BIT = 11;
  localparam int LEVEL_BIT = 14;
  localparam int TRIG_BIT = 15;
  localparam int DEST_LSB = 24;
  localparam int ARB_LSB = 24;
  localparam int CTRL_SEND_BIT = 0;
  localparam int CTRL_SHORT_BIT = 1;
  localparam int CTRL_SELF_BIT = 2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_RES_LSB = 4;
  localparam int ST_TRIES_LSB = 8;

  // Reset values and identifier constants
  localparam logic [31:0] ENTRY_LO_RST = 32'h0000_0000;
  localparam logic [7:0] DEST_RST = 8'h00;
  localparam logic [3:0] ARB_ID_RST = 4'h0;
  localparam logic [3:0] ARB_ID_MAX = 4'hF;
  localparam logic [3:0] PHYS_ALL_ONES = 4'hF;

  // Bus cycle numbers
  localparam logic [5:0] CYC_START = 6'h01;
  localparam logic [5:0] CYC_ARB_FIRST = 6'h02;
  localparam logic [5:0] CYC_ARB_LAST = 6'h05;
  localparam logic [5:0] CYC_MODE_HI = 6'h06;
  localparam logic [5:0] CYC_MODE_LO = 6'h07;
  localparam logic [5:0] CYC_DATA_LAST = 6'h10;
  localparam logic [5:0] CYC_CSUM = 6'h11;
  localparam logic [5:0] CYC_STAT0 = 6'h13;
  localparam logic [5:0] CYC_STAT1 = 6'h14;
  localparam logic [5:0] CYC_SHORT_END = 6'h15;
  localparam logic [5:0] CYC_EOI_END = 6'h0E;
  localparam logic [5:0] CYC_LP_END = 6'h22;
  localparam logic [5:0] CYC_RR_END = 6'h27;

  // Delivery mode codes and wire patterns
  localparam logic [2:0] DLV_FIXED = 3'h0;
  localparam logic [2:0] DLV_LOWEST = 3'h1;
  localparam logic [2:0] DLV_REMOTE = 3'h3;
  localparam logic [1:0] WIRE_IDLE = 2'h3;
  localparam logic [1:0] WIRE_START = 2'h2;

  typedef enum logic [2:0] {RES_NONE, RES_ACCEPTED, RES_FOCUS, RES_LP_ARB, RES_ERROR} res_e;

endpackage

// File: rtl/bus_sampler.sv
// Synchroniser and rising-edge finder for the serial interrupt bus wires
`timescale 1ns/100ps
module bus_sampler
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bus_clk_i,
  input wire logic [1:0] wire_i,
  output logic rise_o,
  output logic [1:0] wire_o
);

  logic clk_s1_q;
  logic clk_s2_q;
  logic clk_s3_q;
  logic [1:0] wire_s1_q;
  logic [1:0] wire_s2_q;

  // Two flops on every pin, a third on the clock for edge finding
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      wire_s1_q <= 2'h3;
      wire_s2_q <= 2'h3;
    end
    else
    begin
      clk_s1_q <= bus_clk_i;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      wire_s1_q <= wire_i;
      wire_s2_q <= wire_s1_q;
    end
  end

  // Data seen with the edge share the same synchroniser delay
  assign rise_o = clk_s2_q & ~clk_s3_q;
  assign wire_o = wire_s2_q;

endmodule

// File: rtl/status_decode.sv
// Decoder for the two status cycles of a short message
`timescale 1ns/100ps
module status_decode
  import irq_msg_pkg::*;
(
  input wire logic [2:0] mode_i,
  input wire logic [1:0] stat0_i,
  input wire logic [1:0] stat1_i,
  output logic retry_o,
  output res_e res_o
);

  logic lowest;
  logic fixed;
  logic cs_good;

  assign lowest = (mode_i == DLV_LOWEST);
  assign fixed = (mode_i == DLV_FIXED);
  assign cs_good = (stat0_i == 2'h3);

  // Retry on checksum error, fixed 00, or lowest-priority end and retry
  assign retry_o = (stat0_i == 2'h0)
    | (cs_good & (stat1_i == 2'h0) & fixed)
    | (cs_good & (stat1_i == 2'h1) & lowest);

  // Final outcome when no retry is called for
  always_comb
  begin
    res_o = RES_ERROR;
    if (stat0_i == 2'h1 && lowest)
      res_o = RES_FOCUS;
    else if (cs_good && stat1_i == 2'h1 && !lowest)
      res_o = RES_ACCEPTED;
    else if (cs_good && stat1_i == 2'h0 && lowest)
      res_o = RES_LP_ARB;
  end

endmodule

// File: rtl/irq_short_sender.sv
// Sender of short interrupt messages on the two-wire serial interrupt bus
// Behaviour
// - A short message lasts 21 bus cycles including its idle cycle
// - Cycle 6 drives inverted destination mode and inverted top delivery bit
// - Cycle 7 drives the two low delivery mode bits inverted
// - Cycle 8 drives inverted level and inverted trigger mode
// - Cycles 9 to 12 drive the inverted vector, two bits each, MSB first
// - Cycles 13 to 16 drive the inverted destination, MSB first
// - Physical mode sends the identifier in cycles 15-16, cycles 13-14 high
// - Logical mode sends all eight destination bits; receivers interpret them
// - Broadcast uses physical mode, all-ones identifier; self response chosen locally
// - Checksum is sum mod 4 of all data bits, driven inverted in 17
// - Cycle 18 is a postamble with both wires released
// - A receiver with a checksum mismatch pulls 00 in cycle 19
// - After a checksum error the message is resent from arbitration
// - First status: 11 good, 00 checksum error, else error or focus
// - Second status: 1x error, 01 accepted, 00 retry only for fixed
// - Lowest priority without focus: 00 arbitration, 01 retry, 1x error
// - Arbitration identifier in bits 27:24, rotated after successful messages
// - Two open-drain wire-OR data wires plus a bus clock wire
`timescale 1ns/100ps
module irq_short_sender
  import irq_msg_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic BUS_CLK_I,
  input wire logic BUS_D0_I,
  output logic BUS_D0_O,
  output logic BUS_D0_OE_O,
  input wire logic BUS_D1_I,
  output logic BUS_D1_O,
  output logic BUS_D1_OE_O,
  output logic SELF_DELIVER_O,
  output logic BUSY_O
);

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_OBSERVE} state_e;

  state_e state_q, state_d;
  logic [5:0] cyc_q, cyc_d;
  logic [1:0] drv_q, drv_d;
  logic [31:0] entry_lo_q, rdata_q;
  logic [7:0] dest_q, tries_q;
  logic [3:0] arb_id_q, arb_id_d, win_id_q;
  logic short_q, self_q, pending_q, done_q, snap_self_q, obs_eoi_q, self_pulse_q;
  res_e res_q, dec_res;
  logic [21:0] msg_q;
  logic [1:0] stat0_q, stat1_q;
  logic [2:0] obs_mode_q, mode_sel;

  logic rise, dec_retry, at_end, run_done, obs_done, msg_ok, lost;
  logic [1:0] smp, csum, lvl;
  logic [5:0] end_cyc;

  // Register decode
  logic wr_entry_lo, wr_entry_hi, wr_arb, wr_ctrl, wr_status, send_req, tx_dest_mode;
  logic [7:0] tx_dest;

  assign wr_entry_lo = WR_I & (ADDR_I == OFF_ENTRY_LO);
  assign wr_entry_hi = WR_I & (ADDR_I == OFF_ENTRY_HI);
  assign wr_arb = WR_I & (ADDR_I == OFF_ARB_ID);
  assign wr_ctrl = WR_I & (ADDR_I == OFF_CTRL);
  assign wr_status = WR_I & (ADDR_I == OFF_STATUS);
  assign send_req = wr_ctrl & WDATA_I[CTRL_SEND_BIT] & ~BUSY_O;

  // Bus pin synchroniser and edge finder
  bus_sampler u_sampler
  (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .bus_clk_i(BUS_CLK_I),
    .wire_i({BUS_D1_I, BUS_D0_I}),
    .rise_o(rise),
    .wire_o(smp)
  );

  // Status decode for our own or an observed message
  assign mode_sel = (state_q == ST_RUN) ? msg_q[20:18] : obs_mode_q;

  status_decode u_decode
  (
    .mode_i(mode_sel),
    .stat0_i(stat0_q),
    .stat1_i(stat1_q),
    .retry_o(dec_retry),
    .res_o(dec_res)
  );

  // Message image: shorthand forces physical mode and an all-ones identifier
  assign tx_dest_mode = WDATA_I[CTRL_SHORT_BIT] ? 1'b0 : entry_lo_q[DESTMODE_BIT];
  assign tx_dest = WDATA_I[CTRL_SHORT_BIT] ? {4'h0, PHYS_ALL_ONES}
    : (tx_dest_mode ? dest_q
    : {4'h0, dest_q[3:0]});

  // Checksum over the 22 data bits, kept modulo 4
  assign csum = 2'($countones(msg_q));

  // Wire level for the next cycle of our own message
  always_comb
  begin
    lvl = WIRE_IDLE;
    if (cyc_d == CYC_START)
      lvl = WIRE_START;
    else if (cyc_d >= CYC_ARB_FIRST && cyc_d <= CYC_ARB_LAST)
      lvl = {~arb_id_q[2'(CYC_ARB_LAST - cyc_d)], 1'b1};
    else if (cyc_d >= CYC_MODE_HI && cyc_d <= CYC_DATA_LAST)
      lvl = ~msg_q[5'(2 * (CYC_DATA_LAST - cyc_d)) +: 2];
    else if (cyc_d == CYC_CSUM)
      lvl = ~csum;
  end

  // Message length depends on format and on the status returned
  always_comb
  begin
    end_cyc = CYC_SHORT_END;
    if (state_q == ST_OBSERVE && obs_eoi_q)
      end_cyc = CYC_EOI_END;
    else if (state_q == ST_OBSERVE && obs_mode_q == DLV_REMOTE)
      end_cyc = CYC_RR_END;
    else if (!dec_retry && dec_res == RES_LP_ARB)
      end_cyc = CYC_LP_END;
  end

  assign at_end = rise & (cyc_q == end_cyc);
  assign run_done = at_end & (state_q == ST_RUN);
  assign obs_done = at_end & (state_q == ST_OBSERVE);
  assign msg_ok = ~dec_retry & (dec_res != RES_ERROR);

  // Arbitration loss: bus pulled low where we released it
  assign lost = rise & (state_q == ST_RUN) & (cyc_q <= CYC_ARB_LAST) & drv_q[1] & ~smp[1];

  // Bus cycle sequencing
  always_comb
  begin
    state_d = state_q;
    cyc_d = cyc_q;
    if (rise)
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (!smp[0])
          begin
            state_d = ST_OBSERVE;
            cyc_d = CYC_ARB_FIRST;
          end
          else if (pending_q && smp == WIRE_IDLE)
          begin
            state_d = ST_RUN;
            cyc_d = CYC_START;
          end
        end
        ST_RUN, ST_OBSERVE:
        begin
          cyc_d = cyc_q + 6'h01;
          if (lost)
            state_d = ST_OBSERVE;
          if (at_end)
          begin
            state_d = ST_IDLE;
            cyc_d = 6'h00;
          end
        end
      endcase
    end
  end

  assign drv_d = (state_d == ST_RUN) ? lvl : WIRE_IDLE;

  // Sequencer state and wire drive
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      state_q <= ST_IDLE;
      cyc_q <= 6'h00;
      drv_q <= WIRE_IDLE;
    end
    else if (rise)
    begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      drv_q <= drv_d;
    end
  end

  // Open drain: only ever pull low, release for a high level
  assign BUS_D0_O = 1'b0;
  assign BUS_D1_O = 1'b0;
  assign BUS_D0_OE_O = ~drv_q[0];
  assign BUS_D1_OE_O = ~drv_q[1];

  // Capture of status cycles and of observed message fields
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      stat0_q <= WIRE_IDLE;
      stat1_q <= WIRE_IDLE;
      obs_mode_q <= DLV_FIXED;
      obs_eoi_q <= 1'b0;
      win_id_q <= ARB_ID_RST;
    end
    else if (rise)
    begin
      if (cyc_q == CYC_STAT0)
        stat0_q <= smp;
      if (cyc_q == CYC_STAT1)
        stat1_q <= smp;
      if (state_q == ST_IDLE)
        obs_eoi_q <= ~smp[1];
      else if (lost && cyc_q == CYC_START)
        obs_eoi_q <= 1'b1;
      if (cyc_q >= CYC_ARB_FIRST && cyc_q <= CYC_ARB_LAST)
        win_id_q <= {win_id_q[2:0], ~smp[1]};
      if (cyc_q == CYC_MODE_HI)
        obs_mode_q[2] <= ~smp[0];
      if (cyc_q == CYC_MODE_LO)
        obs_mode_q[1:0] <= ~smp;
    end
  end

  // Arbitration identifier: software write, or rotation after a good message
  always_comb
  begin
    arb_id_d = arb_id_q;
    if (wr_arb)
      arb_id_d = WDATA_I[ARB_LSB +: 4];
    if (run_done && msg_ok)
      arb_id_d = ARB_ID_RST;
    else if (obs_done && msg_ok && !obs_eoi_q)
      arb_id_d = (arb_id_q == ARB_ID_MAX) ? win_id_q + 4'h1 : arb_id_q + 4'h1;
  end

  // Software-visible configuration and message snapshot
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      entry_lo_q <= ENTRY_LO_RST;
      dest_q <= DEST_RST;
      arb_id_q <= ARB_ID_RST;
      short_q <= 1'b0;
      self_q <= 1'b0;
      msg_q <= 22'h000000;
      snap_self_q <= 1'b0;
    end
    else
    begin
      arb_id_q <= arb_id_d;
      if (wr_entry_lo)
        entry_lo_q <= WDATA_I;
      if (wr_entry_hi)
        dest_q <= WDATA_I[DEST_LSB +: 8];
      if (wr_ctrl)
      begin
        short_q <= WDATA_I[CTRL_SHORT_BIT];
        self_q <= WDATA_I[CTRL_SELF_BIT];
      end
      if (send_req)
      begin
        msg_q <= {tx_dest_mode, entry_lo_q[DMODE_LSB +: 3], entry_lo_q[LEVEL_BIT],
          entry_lo_q[TRIG_BIT], entry_lo_q[VEC_LSB +: 8], tx_dest};
        snap_self_q <= WDATA_I[CTRL_SHORT_BIT] & WDATA_I[CTRL_SELF_BIT];
      end
    end
  end

  // Request, completion and outcome tracking
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      pending_q <= 1'b0;
      done_q <= 1'b0;
      res_q <= RES_NONE;
      tries_q <= 8'h00;
      self_pulse_q <= 1'b0;
    end
    else
    begin
      self_pulse_q <= run_done & msg_ok & snap_self_q;
      if (send_req)
      begin
        pending_q <= 1'b1;
        tries_q <= 8'h00;
        res_q <= RES_NONE;
      end
      else if (lost || (run_done && dec_retry))
        tries_q <= tries_q + 8'h01;
      else if (run_done)
      begin
        pending_q <= 1'b0;
        res_q <= dec_res;
      end
      if (run_done && !dec_retry)
        done_q <= 1'b1;
      else if (wr_status && WDATA_I[ST_DONE_BIT])
        done_q <= 1'b0;
    end
  end

  // Read data, valid in the cycle after the read strobe
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      rdata_q <= 32'h0000_0000;
    else if (RD_I)
    begin
      unique case (ADDR_I)
        OFF_ENTRY_LO: rdata_q <= entry_lo_q;
        OFF_ENTRY_HI: rdata_q <= {dest_q, 24'h000000};
        OFF_ARB_ID: rdata_q <= {4'h0, arb_id_q, 24'h000000};
        OFF_CTRL: rdata_q <= {29'h0, self_q, short_q, pending_q};
        OFF_STATUS: rdata_q <= {16'h0000, tries_q, 1'b0, 3'(res_q), 2'h0, done_q, BUSY_O};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
    else
      rdata_q <= 32'h0000_0000;
  end

  assign RDATA_O = rdata_q;
  assign BUSY_O = pending_q | (state_q == ST_RUN);
  assign SELF_DELIVER_O = self_pulse_q;

endmodule

// File: verif/irq_short_sender_chk.sv
// Checker of own short message frames at the sender ports
`timescale 1ns/100ps
module irq_short_sender_chk
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic BUS_CLK_I,
  input wire logic BUS_D0_O,
  input wire logic BUS_D0_OE_O,
  input wire logic BUS_D1_O,
  input wire logic BUS_D1_OE_O,
  input wire logic SELF_DELIVER_O,
  input wire logic BUSY_O
);
  logic [2:0] sy_q;
  logic [3:0] mid_q;
  logic [4:0] cyc_q;
  logic [1:0] sum_q;
  logic dest_mode_q;
  wire [1:0] oe = {BUS_D1_OE_O, BUS_D0_OE_O};
  wire rise = sy_q[1] & ~sy_q[2];
  wire at = mid_q[3];
  wire step = mid_q[2];
  // Counts own frame cycles at a mid-cycle strobe, sums driven data bits
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      sy_q <= 3'h0;
      mid_q <= 4'h0;
      cyc_q <= 5'h0;
      sum_q <= 2'h0;
      dest_mode_q <= 1'b0;
    end
    else
    begin
      sy_q <= {sy_q[1:0], BUS_CLK_I};
      mid_q <= {mid_q[2:0], rise};
      if (step && (cyc_q == 5'h0 || cyc_q == 5'h15))
        cyc_q <= {4'h0, BUS_D0_OE_O};
      else if (step)
        cyc_q <= cyc_q + 5'h1;
      if (step && cyc_q < 5'h5)
        sum_q <= 2'h0;
      else if (step && cyc_q <= 5'hF)
        sum_q <= sum_q + {1'b0, oe[1]} + {1'b0, oe[0]};
      if (step && cyc_q == 5'h5)
        dest_mode_q <= oe[1];
    end
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  sequence s_cyc(logic [4:0] n);
    at && cyc_q == n;
  endsequence
  a_open_drain: assert property (BUS_D0_O == 1'b0 && BUS_D1_O == 1'b0)
    else $error("Bus drive value is not low");
  a_start_code: assert property (s_cyc(5'h1) |-> oe == 2'b01)
    else $error("Start cycle pattern wrong");
  a_arb_bit0_free: assert property (at && cyc_q inside {[2:5]} |-> !BUS_D0_OE_O)
    else $error("Bit 0 pulled in arbitration");
  a_phys_upper_high: assert property (at && cyc_q inside {[13:14]} && !dest_mode_q
    |-> oe == 2'b00)
    else $error("Physical upper destination not high");
  a_csum_sent: assert property (s_cyc(5'h11) |-> oe == sum_q)
    else $error("Checksum cycle wrong");
  a_tail_released: assert property (at && cyc_q >= 5'h12 |-> oe == 2'b00)
    else $error("Wires pulled after checksum");
  a_busy_in_frame: assert property (at && cyc_q != 5'h0 |-> BUSY_O)
    else $error("Busy low inside own frame");
  a_self_pulse: assert property ($rose(SELF_DELIVER_O) |=> !SELF_DELIVER_O)
    else $error("Self delivery pulse too long");
endmodule

// File: verif/bus_partner.sv
// Far-side receiver model on the serial interrupt bus
`timescale 1ns/100ps
module bus_partner
(
  input wire logic d0_i,
  input wire logic d1_i,
  input wire logic [1:0] s0_i,
  input wire logic [1:0] s1_i,
  output logic clk_o,
  output logic [1:0] pull_o,
  output logic [41:0] frame_o,
  output int frames_o
);
  int cnt = 0;
  logic [1:0] sum = 2'h0;
  logic cerr = 1'b0;
  // Free-running bus clock, phase unrelated to the system clock
  initial
  begin
    clk_o = 1'b0;
    pull_o = 2'b00;
    frames_o = 0;
    #13;
    forever #200 clk_o = ~clk_o;
  end
  // Records levels at cycle ends and checks the sum of data bits
  always @(posedge clk_o)
  begin
    frame_o <= {frame_o[39:0], d1_i, d0_i};
    if (cnt == 0)
      cnt <= (d0_i == 1'b0) ? 1 : 0;
    else
      cnt <= (cnt == 20) ? 0 : cnt + 1;
    if (cnt < 5)
      sum <= 2'h0;
    else if (cnt <= 15)
      sum <= sum + {1'b0, !d1_i} + {1'b0, !d0_i};
    if (cnt == 16)
      cerr <= ({!d1_i, !d0_i} != sum);
    if (cnt == 20)
      frames_o <= frames_o + 1;
  end
  // Pulls the wires low only in the status cycles
  always @(negedge clk_o)
    pull_o <= (cnt == 18) ? (cerr ? 2'b11 : ~s0_i) : (cnt == 19) ? ~s1_i : 2'b00;
endmodule

// File: verif/testbench.sv
// Self-checking bench for the short interrupt message sender
`timescale 1ns/100ps
module testbench
  import irq_msg_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [31:0] rdata;
  logic oe0, oe1, slf, busy;
  logic [1:0] s0c = 2'b11;
  logic [1:0] s1c = 2'b11;
  wire bclk;
  wire [1:0] pull;
  wire [41:0] fr;
  int frames;
  int err_total = 0;
  int total_checks = 0;
  int seed = 32'h4585431d;
  int cyc = 0;
  int selfs = 0;
  logic [8:0] tbl [13] = '{9'h034, 9'h030, 9'h0B0, 9'h138, 9'h16C, 9'h1CC, 9'h05C,
    9'h070, 9'h074, 9'h07C, 9'h01C, 9'h037, 9'h135};
  // Open-drain wires with pull-up
  wire w0 = ~oe0 & ~pull[0];
  wire w1 = ~oe1 & ~pull[1];
  irq_short_sender irq_short_sender_i (.CLOCK_I(clk), .RST_I(rst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(we), .RD_I(re), .RDATA_O(rdata), .BUS_CLK_I(bclk),
    .BUS_D0_I(w0), .BUS_D0_O(), .BUS_D0_OE_O(oe0), .BUS_D1_I(w1), .BUS_D1_O(),
    .BUS_D1_OE_O(oe1), .SELF_DELIVER_O(slf), .BUSY_O(busy));
  bus_partner bus_partner_i (.d0_i(w0), .d1_i(w1), .s0_i(s0c), .s1_i(s1c), .clk_o(bclk),
    .pull_o(pull), .frame_o(fr), .frames_o(frames));
  // System clock
  initial
  begin
    forever #25 clk = ~clk;
  end
  // Cycle limit and self delivery counting
  always @(posedge clk)
  begin
    cyc++;
    if (slf === 1'b1)
      selfs++;
    if (cyc == 30000)
    begin
      err_total++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [41:0] seen, input logic [41:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic wait_frame(input int n0);
    for (int k = 0; k < 400 && frames == n0; k++)
      @(posedge clk);
    chk("frame arrival", 42'(frames != n0), 42'h1);
  endtask
  // Wire levels of a whole short frame, cycle 1 first
  function automatic logic [41:0] exp_frame(input logic [15:0] e, input logic [7:0] dst,
      input logic [3:0] arb, input logic [1:0] s0, input logic [1:0] s1);
    logic [7:0] db;
    logic [7:0] dw;
    logic [1:0] cs;
    db = e[11] ? dst : {4'h0, dst[3:0]};
    dw = e[11] ? ~dst : {4'hF, ~dst[3:0]};
    cs = 2'($countones({e[11], e[10:8], e[14], e[15], e[7:0], db}));
    return {2'b10, ~arb[3], 1'b1, ~arb[2], 1'b1, ~arb[1], 1'b1, ~arb[0], 1'b1,
      ~e[11], ~e[10:8], ~e[14], ~e[15], ~e[7:0], dw, ~cs, 2'b11, s0, s1, 2'b11};
  endfunction
  // Retry flag and result code from the status levels
  function automatic logic [3:0] exp_res(input logic [2:0] m, input logic [1:0] s0,
      input logic [1:0] s1);
    if (s0 == 2'b00)
      return 4'h8;
    if (m == DLV_LOWEST && s0 == 2'b01)
      return 4'h2;
    if (s0 != 2'b11 || s1[1])
      return 4'h4;
    if (m == DLV_LOWEST)
      return (s1 == 2'b00) ? 4'h3 : 4'h8;
    if (s1 == 2'b01)
      return 4'h1;
    return (m == DLV_FIXED) ? 4'h8 : 4'h4;
  endfunction
  // Reset, register checks, then one message per table row
  initial
  begin
    logic [31:0] d;
    logic [15:0] e;
    logic [7:0] dst;
    logic [3:0] arb;
    logic [3:0] r;
    logic [8:0] t;
    logic [1:0] ok0;
    logic [1:0] ok1;
    logic [41:0] x;
    int n;
    int sc;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_ENTRY_LO, d);
    chk("entry reset", d, ENTRY_LO_RST);
    rd(OFF_ARB_ID, d);
    chk("arb reset", d[27:24], ARB_ID_RST);
    rd(8'h14, d);
    chk("unmapped", d, 32'h0);
    for (int i = 0; i < 13; i++)
    begin
      t = tbl[i];
      e = 16'($random(seed));
      e[10:8] = t[8:6];
      e[11] = e[11] & ~t[0];
      dst = t[0] ? 8'hFF : 8'($random(seed));
      arb = 4'($random(seed));
      s0c = t[5:4];
      s1c = t[3:2];
      r = exp_res(t[8:6], t[5:4], t[3:2]);
      ok0 = (t[8:6] == DLV_LOWEST) ? 2'b01 : 2'b11;
      ok1 = (t[8:6] == DLV_LOWEST) ? 2'b11 : 2'b01;
      wr(OFF_ENTRY_LO, {16'h0, e});
      wr(OFF_ENTRY_HI, {dst, 24'h0});
      wr(OFF_ARB_ID, {4'h0, arb, 24'h0});
      n = frames;
      sc = selfs;
      wr(OFF_CTRL, {29'h0, t[1:0], 1'b1});
      wait_frame(n);
      chk("frame", fr, exp_frame(e, dst, arb, t[5:4], t[3:2]));
      if (r[3])
      begin
        s0c = ok0;
        s1c = ok1;
        wait_frame(n + 1);
        x = exp_frame(e, dst, arb, ok0, ok1);
        chk("resent frame", fr[31:0], x[31:0]);
        r = exp_res(t[8:6], ok0, ok1) | 4'h8;
      end
      for (int k = 0; k < 400 && busy !== 1'b0; k++)
        @(posedge clk);
      rd(OFF_STATUS, d);
      chk("status", {d[15:8], d[6:4], d[1:0]}, {7'h0, r[3], r[2:0], 2'b10});
      chk("self delivery", 42'(selfs - sc), {41'h0, t[1:0] == 2'b11});
      rd(OFF_ARB_ID, d);
      if (r[2:0] == 3'h1)
        chk("arb after accept", d[27:24], 4'h0);
    end
    wr(OFF_STATUS, 32'h2);
    rd(OFF_STATUS, d);
    chk("done clear", d[1:0], 2'b00);
    end_sim();
  end
endmodule
bind irq_short_sender irq_short_sender_chk irq_short_sender_chk_i (.CLOCK_I(CLOCK_I),
  .RST_I(RST_I), .BUS_CLK_I(BUS_CLK_I), .BUS_D0_O(BUS_D0_O), .BUS_D0_OE_O(BUS_D0_OE_O),
  .BUS_D1_O(BUS_D1_O), .BUS_D1_OE_O(BUS_D1_OE_O), .SELF_DELIVER_O(SELF_DELIVER_O),
  .BUSY_O(BUSY_O));
